// ===== design/tec_pkg.sv
package tec_pkg;

    // ==========================================================
    // register map (word aligned byte addresses)
    // ==========================================================
    localparam logic [11:0] TEC_OFS_COUNT    = 12'h000;
    localparam logic [11:0] TEC_OFS_CONTROL  = 12'h004;
    localparam logic [11:0] TEC_OFS_INTCTL   = 12'h008;
    localparam logic [11:0] TEC_OFS_PORT_DIR = 12'h00C;
    localparam logic [11:0] TEC_OFS_PORT_DAT = 12'h010;

    // ==========================================================
    // widths and values
    // ==========================================================
    localparam int unsigned TEC_PORT_W  = 8;
    localparam int unsigned TEC_PRESC_W = 7;

    localparam logic [7:0]  TEC_COUNT_FULL    = 8'hFF;
    localparam logic [7:0]  TEC_COUNT_RESET   = 8'h00;
    localparam logic [7:0]  TEC_PRELOAD_RESET = 8'h00;
    localparam logic [7:0]  TEC_PORT_RESET    = 8'hFF;
    localparam logic [6:0]  TEC_PRESC_ONE     = 7'h01;
    localparam logic [7:0]  TEC_COUNT_ONE     = 8'h01;
    localparam int unsigned TEC_INTEN_BIT     = 0;

    // ==========================================================
    // mode field encodings
    // ==========================================================
    localparam logic [1:0] TEC_MODE_OFF   = 2'h0;
    localparam logic [1:0] TEC_MODE_EVENT = 2'h1;
    localparam logic [1:0] TEC_MODE_TIMER = 2'h2;
    localparam logic [1:0] TEC_MODE_PULSE = 2'h3;

    // ==========================================================
    // types
    // ==========================================================
    // layout gives mode 7:6, spare 5, run 4, edge 3, prescale 2:0
    typedef struct packed {
        logic [1:0] mode_select_pair;
        logic       spare;
        logic       counter_run_bit;
        logic       edge_select_bit;
        logic [2:0] prescale_select;
    } tec_ctrl_type;

    typedef enum logic [1:0] {
        TEC_PW_IDLE = 2'b01,
        TEC_PW_MEAS = 2'b10
    } tec_pw_state_type;

    typedef struct packed {
        tec_ctrl_type     timer_control;
        logic [7:0]       count;
        logic [7:0]       preload;
        logic             int_en;
        logic [7:0]       port_dir;
        logic [7:0]       port_dat;
        logic [7:0]       port_oe;
        logic             pin_prev;
        tec_pw_state_type pw;
        logic [6:0]       presc;
        logic             irq;
        logic [31:0]      prdata;
        logic             pready;
        logic             pslverr;
    } tec_state_type;

endpackage

// ===== design/tec_timer.sv
// The register addresses and register access over APB are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - one 8-bit up counter holds the live count
// - the shared pin reaches the counter only in event or pulse modes
// - port data and direction registers reset to all ones, pins are inputs
// - mode comes from control bits 7 and 6
// - mode 10 is the timer mode
// - control bit 4 runs the counter when high, stops it when low
// - timer and pulse modes count the prescaled system clock
// - control bits 2 to 0 choose the prescale ratio
// - pin clocked counting ignores the prescale field
// - event mode adds exactly one per qualifying pin edge
// - control bit 3 picks the active pin edge in event and pulse modes
// - count climbs to FF, next step overflows and raises a request
// - overflow reloads the preload value and counting goes on
// - preload write while stopped is copied into the live count
// - preload write while running waits for the next overflow
// - reading the count register returns the live count
// - preload starts at 00 after reset
// - the overflow request passes only while interrupt enable is set
// - mode 01 is the event counter mode
// - event mode edge bit low counts rising, high counts falling
// - pulse mode edge low measures a low pulse, high a high pulse
// - pulse end clears run and later edges are ignored
module tec_timer #(
    parameter int unsigned ADDR_W        = 12,
    parameter int unsigned TIMER_PIN_BIT = 0
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic [7:0]        port_in,
    output logic      [7:0]        port_out,
    output logic      [7:0]        port_oe,
    output logic                   timer_irq
);

    // ==========================================================
    // helpers
    // ==========================================================
    function automatic logic presc_tick(input logic [6:0] p, input logic [2:0] sel);
        logic [6:0] m;
        m = (tec_pkg::TEC_PRESC_ONE << sel) - tec_pkg::TEC_PRESC_ONE;
        return (p & m) == m;
    endfunction

    function automatic logic is_mapped(input logic [11:0] a);
        return a == tec_pkg::TEC_OFS_COUNT || a == tec_pkg::TEC_OFS_CONTROL
            || a == tec_pkg::TEC_OFS_INTCTL || a == tec_pkg::TEC_OFS_PORT_DIR
            || a == tec_pkg::TEC_OFS_PORT_DAT;
    endfunction

    tec_pkg::tec_state_type st_reg;
    tec_pkg::tec_state_type st_next;

    logic [11:0] addr;
    logic        wr_acc;
    logic        setup;
    logic        pin_now;
    logic        ext_sel;
    logic        rise;
    logic        fall;
    logic        ev_edge;
    logic        pw_start;
    logic        pw_end;
    logic        tick;
    logic        inc;
    logic        ovf;
    logic [1:0]  mode;
    logic        run;
    logic        edge_hi;

    assign addr    = 12'(paddr);
    assign setup   = psel & ~penable;
    assign wr_acc  = psel & penable & st_reg.pready & pwrite;
    assign mode    = st_reg.timer_control.mode_select_pair;
    assign run     = st_reg.timer_control.counter_run_bit;
    assign edge_hi = st_reg.timer_control.edge_select_bit;
    assign pin_now = port_in[TIMER_PIN_BIT];

    // ==========================================================
    // pin edges
    // ==========================================================
    // pin only steers the count in the two external modes
    assign ext_sel  = (mode == tec_pkg::TEC_MODE_EVENT) || (mode == tec_pkg::TEC_MODE_PULSE);
    assign rise     = ext_sel & pin_now & ~st_reg.pin_prev;
    assign fall     = ext_sel & ~pin_now & st_reg.pin_prev;
    assign ev_edge  = edge_hi ? fall : rise;
    assign pw_start = edge_hi ? rise : fall;
    assign pw_end   = edge_hi ? fall : rise;
    assign tick     = presc_tick(st_reg.presc, st_reg.timer_control.prescale_select);

    // ==========================================================
    // count enable and overflow
    // ==========================================================
    always_comb
    begin
        inc = 1'b0;
        case (mode)
            tec_pkg::TEC_MODE_TIMER: inc = run & tick;
            tec_pkg::TEC_MODE_EVENT: inc = run & ev_edge;
            tec_pkg::TEC_MODE_PULSE: inc = run & (st_reg.pw == tec_pkg::TEC_PW_MEAS)
                                           & tick & ~pw_end;
            default:                 inc = 1'b0;
        endcase
    end

    assign ovf = inc & (st_reg.count == tec_pkg::TEC_COUNT_FULL);

    // ==========================================================
    // next state
    // ==========================================================
    always_comb
    begin
        st_next = st_reg;
        st_next.pin_prev = pin_now;

        // prescaler held at zero when idle so the first period is whole
        if (run && (mode == tec_pkg::TEC_MODE_TIMER
            || (mode == tec_pkg::TEC_MODE_PULSE && st_reg.pw == tec_pkg::TEC_PW_MEAS)))
        begin
            st_next.presc = st_reg.presc + tec_pkg::TEC_PRESC_ONE;
        end
        else
        begin
            st_next.presc = '0;
        end

        if (inc)
        begin
            if (ovf)
            begin
                st_next.count = st_reg.preload;
            end
            else
            begin
                st_next.count = st_reg.count + tec_pkg::TEC_COUNT_ONE;
            end
        end

        st_next.irq = ovf & st_reg.int_en;

        // single shot pulse capture
        case (st_reg.pw)
            tec_pkg::TEC_PW_IDLE:
            begin
                if (run && mode == tec_pkg::TEC_MODE_PULSE && pw_start)
                begin
                    st_next.pw = tec_pkg::TEC_PW_MEAS;
                end
            end
            tec_pkg::TEC_PW_MEAS:
            begin
                if (!run || mode != tec_pkg::TEC_MODE_PULSE)
                begin
                    st_next.pw = tec_pkg::TEC_PW_IDLE;
                end
                else if (pw_end)
                begin
                    st_next.pw = tec_pkg::TEC_PW_IDLE;
                    st_next.timer_control.counter_run_bit = 1'b0;
                end
            end
            default: st_next.pw = tec_pkg::TEC_PW_IDLE;
        endcase

        // software write comes last so a run set beats the hardware clear
        if (wr_acc)
        begin
            case (addr)
                tec_pkg::TEC_OFS_COUNT:
                begin
                    st_next.preload = pwdata[7:0];
                    if (!run)
                    begin
                        st_next.count = pwdata[7:0];
                    end
                end
                tec_pkg::TEC_OFS_CONTROL:
                begin
                    st_next.timer_control       = pwdata[7:0];
                    st_next.timer_control.spare = 1'b0;
                end
                tec_pkg::TEC_OFS_INTCTL:   st_next.int_en = pwdata[tec_pkg::TEC_INTEN_BIT];
                tec_pkg::TEC_OFS_PORT_DIR: st_next.port_dir = pwdata[7:0];
                tec_pkg::TEC_OFS_PORT_DAT: st_next.port_dat = pwdata[7:0];
                default:                   st_next.preload = st_reg.preload;
            endcase
        end
        // direction bit high means input, so the driver is off
        st_next.port_oe = ~st_next.port_dir;

        // apb: answer is prepared in setup, so every access has no wait
        if (setup)
        begin
            st_next.pready  = 1'b1;
            st_next.pslverr = ~is_mapped(addr);
            st_next.prdata  = '0;
            case (addr)
                tec_pkg::TEC_OFS_COUNT:    st_next.prdata[7:0] = st_reg.count;
                tec_pkg::TEC_OFS_CONTROL:  st_next.prdata[7:0] = st_reg.timer_control;
                tec_pkg::TEC_OFS_INTCTL:
                    st_next.prdata[tec_pkg::TEC_INTEN_BIT] = st_reg.int_en;
                tec_pkg::TEC_OFS_PORT_DIR: st_next.prdata[7:0] = st_reg.port_dir;
                tec_pkg::TEC_OFS_PORT_DAT:
                    st_next.prdata[7:0] = (port_in & st_reg.port_dir)
                                        | (st_reg.port_dat & ~st_reg.port_dir);
                default:                   st_next.prdata = '0;
            endcase
        end
        else if (st_reg.pready)
        begin
            st_next.pready  = 1'b0;
            st_next.pslverr = 1'b0;
        end
    end

    // ==========================================================
    // state register
    // ==========================================================
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_reg.timer_control <= '0;
            st_reg.count         <= tec_pkg::TEC_COUNT_RESET;
            st_reg.preload       <= tec_pkg::TEC_PRELOAD_RESET;
            st_reg.int_en        <= 1'b0;
            st_reg.port_dir      <= tec_pkg::TEC_PORT_RESET;
            st_reg.port_dat      <= tec_pkg::TEC_PORT_RESET;
            st_reg.port_oe       <= '0;
            st_reg.pin_prev      <= 1'b1; // pin idles high on its pull-up, no false edge
            st_reg.pw            <= tec_pkg::TEC_PW_IDLE;
            st_reg.presc         <= '0;
            st_reg.irq           <= 1'b0;
            st_reg.prdata        <= '0;
            st_reg.pready        <= 1'b0;
            st_reg.pslverr       <= 1'b0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign prdata    = st_reg.prdata;
    assign pready    = st_reg.pready;
    assign pslverr   = st_reg.pslverr;
    assign port_out  = st_reg.port_dat;
    assign port_oe   = st_reg.port_oe;
    assign timer_irq = st_reg.irq;

    // ==========================================================
    // checks
    // ==========================================================
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_pulse_end;
        run && mode == tec_pkg::TEC_MODE_PULSE && st_reg.pw == tec_pkg::TEC_PW_MEAS
            && pw_end && !wr_acc;
    endsequence

    sequence s_stopped_quiet;
        !run && st_reg.pw == tec_pkg::TEC_PW_IDLE;
    endsequence

    chk_reset_ports: assert property ($rose(presetn) |->
        st_reg.port_dir == tec_pkg::TEC_PORT_RESET && port_oe == 8'h00)
        else $error("port registers not all ones after reset");

    chk_off_no_count: assert property (mode == tec_pkg::TEC_MODE_OFF && !wr_acc
        |=> $stable(st_reg.count))
        else $error("count moved in off mode");

    chk_stop_hold: assert property (!run && !wr_acc |=> $stable(st_reg.count))
        else $error("count moved while stopped");

    chk_run_low_hold: assert property (!run && !wr_acc |=> !run)
        else $error("run bit set without a software write");

    // only software or the end of a measured pulse may drop the run bit
    chk_run_hold: assert property (run && !wr_acc && !pw_end |=> run)
        else $error("run bit cleared without cause");

    chk_timer_div1: assert property (run && mode == tec_pkg::TEC_MODE_TIMER
        && st_reg.timer_control.prescale_select == 3'h0 && !wr_acc
        && st_reg.count != tec_pkg::TEC_COUNT_FULL
        |=> st_reg.count == $past(st_reg.count) + tec_pkg::TEC_COUNT_ONE)
        else $error("timer did not step each clock at divide one");

    // the pin may toggle freely in timer mode; only prescaler ticks move the count
    chk_timer_pin_free: assert property (mode == tec_pkg::TEC_MODE_TIMER && !tick
        && !wr_acc |=> $stable(st_reg.count))
        else $error("timer count moved without a prescaler tick");

    chk_event_step: assert property (run && mode == tec_pkg::TEC_MODE_EVENT && ev_edge
        && !wr_acc && st_reg.count != tec_pkg::TEC_COUNT_FULL
        |=> st_reg.count == $past(st_reg.count) + tec_pkg::TEC_COUNT_ONE)
        else $error("event edge did not add one");

    chk_event_no_tick: assert property (mode == tec_pkg::TEC_MODE_EVENT && !ev_edge
        && !wr_acc |=> $stable(st_reg.count))
        else $error("event count moved without a pin edge");

    chk_ovf_reload: assert property (ovf && !wr_acc
        |=> st_reg.count == $past(st_reg.preload))
        else $error("overflow did not reload preload value");

    chk_irq_gate: assert property (ovf |=> timer_irq == $past(st_reg.int_en))
        else $error("overflow request not gated by enable");

    chk_irq_quiet: assert property (!ovf |=> !timer_irq)
        else $error("request raised without an overflow");

    chk_preload_copy: assert property (wr_acc && addr == tec_pkg::TEC_OFS_COUNT && !run
        |=> st_reg.count == $past(pwdata[7:0]) && st_reg.preload == st_reg.count)
        else $error("stopped preload write not copied to count");

    chk_preload_defer: assert property (wr_acc && addr == tec_pkg::TEC_OFS_COUNT && run
        && !inc |=> $stable(st_reg.count))
        else $error("running preload write touched count");

    chk_pulse_arm: assert property (run && mode == tec_pkg::TEC_MODE_PULSE
        && st_reg.pw == tec_pkg::TEC_PW_IDLE && pw_start && !wr_acc
        |=> st_reg.pw == tec_pkg::TEC_PW_MEAS)
        else $error("pulse start edge did not arm the measurement");

    // nothing is counted in pulse mode before the start edge arrives
    chk_pulse_wait: assert property (mode == tec_pkg::TEC_MODE_PULSE
        && st_reg.pw == tec_pkg::TEC_PW_IDLE && !wr_acc |=> $stable(st_reg.count))
        else $error("pulse count moved before the start edge");

    chk_pulse_stop: assert property (s_pulse_end |=> s_stopped_quiet)
        else $error("pulse end did not stop the counter");

    chk_pulse_ignore: assert property (mode == tec_pkg::TEC_MODE_PULSE && !run
        && !wr_acc |=> $stable(st_reg.count) && st_reg.pw == tec_pkg::TEC_PW_IDLE)
        else $error("stopped pulse mode reacted to the pin");

    chk_read_count: assert property (setup && addr == tec_pkg::TEC_OFS_COUNT
        |=> prdata[7:0] == $past(st_reg.count))
        else $error("count read did not return the live count");

    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("ready stood longer than one cycle");

    chk_err_with_ready: assert property (pslverr |-> pready)
        else $error("error response without ready");

endmodule

`default_nettype wire

// ===== verif/tec_pin_source.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// external event or pulse source on the shared timer pin
// ==========================================================
// the pin carries a pull-high, so the source starts and idles high
module tec_pin_source (
    input  wire logic pclk,
    output var  logic pin
);
    initial pin = 1'b1;

    // a level is set just after a rising edge and held whole cycles, so the
    // block's edge detector sees exactly one change per level
    task automatic drive(input logic level, input int hold);
        @(posedge pclk);
        pin <= level;
        repeat (hold) @(posedge pclk);
    endtask
endmodule

`default_nettype wire

// ===== verif/tec_timer_test.sv
`timescale 1ns/1ps
`default_nettype none

module tec_timer_test;
    // ==========================================================
    // signals
    // ==========================================================
    logic        pclk    = 1'b0;
    logic        presetn = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [11:0] paddr   = 12'h000;
    logic [31:0] pwdata  = 32'h00000000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    wire  [7:0]  port_in;
    logic [7:0]  port_out;
    logic [7:0]  port_oe;
    logic        timer_irq;
    wire         src_pin;
    int          err_count    = 0;
    int          total_checks = 0;
    logic [31:0] q;
    logic        e;
    logic [7:0]  held;
    int          n;

    // ==========================================================
    // clock, pin wiring, instances
    // ==========================================================
    initial
    begin
        forever #50 pclk = ~pclk;
    end

    // a driven bit shows the latch; a released bit shows its pull-high or the source
    assign port_in = (port_oe & port_out) | (~port_oe & {7'h7F, src_pin});

    tec_pin_source i_src (.pclk(pclk), .pin(src_pin));

    tec_timer i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .port_in(port_in),
        .port_out(port_out), .port_oe(port_oe), .timer_irq(timer_irq)
    );

    // ==========================================================
    // tasks
    // ==========================================================
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            $display("Error at %0t: got %h expected %h", $time, got, exp);
            err_count++;
        end
    endtask

    // pready and read data are taken at the rising edge itself, before the slave's
    // flip-flops update; only the watchdog ends a wait that never finishes
    task automatic apb(input logic wr_en, input logic [11:0] a, input logic [7:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr_en;
        paddr   <= a;
        pwdata  <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
        begin
            @(posedge pclk);
        end
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 8'h00);
        chk(q, exp);
    endtask

    // n is the number of whole cycles between two irq pulses, minus one
    task automatic wait_irq(input int lim);
        n = 0;
        @(negedge pclk);
        while (timer_irq !== 1'b1 && n < lim)
        begin
            @(negedge pclk);
            n++;
        end
    endtask

    task automatic final_report;
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // ==========================================================
    // tests
    // ==========================================================
    initial
    begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        chk(port_oe, 32'h0);
        rd(tec_pkg::TEC_OFS_PORT_DIR, 32'hFF);
        rd(tec_pkg::TEC_OFS_PORT_DAT, 32'hFF);
        rd(tec_pkg::TEC_OFS_CONTROL, 32'h0);
        rd(12'h014, 32'h0);
        chk(e, 32'h1);
        wr(tec_pkg::TEC_OFS_COUNT, 8'hF0);
        rd(tec_pkg::TEC_OFS_COUNT, 32'hF0);
        wr(tec_pkg::TEC_OFS_INTCTL, 8'h01);
        // every prescale step: reload FE gives an irq every two ticks
        for (int s = 0; s < 8; s++)
        begin
            wr(tec_pkg::TEC_OFS_CONTROL, 8'h00);
            wr(tec_pkg::TEC_OFS_COUNT, 8'hFE);
            wr(tec_pkg::TEC_OFS_CONTROL, {5'b10010, s[2:0]});
            wait_irq(600);
            wait_irq(600);
            chk(n, (2 << s) - 1);
        end
        wr(tec_pkg::TEC_OFS_INTCTL, 8'h00);
        wr(tec_pkg::TEC_OFS_CONTROL, 8'h90);
        wait_irq(40);
        chk(n, 40);
        wr(tec_pkg::TEC_OFS_INTCTL, 8'h01);
        wr(tec_pkg::TEC_OFS_CONTROL, 8'h87);
        wr(tec_pkg::TEC_OFS_COUNT, 8'hFE);
        wr(tec_pkg::TEC_OFS_CONTROL, 8'h97);
        wr(tec_pkg::TEC_OFS_COUNT, 8'h20);
        apb(1'b0, tec_pkg::TEC_OFS_COUNT, 8'h00);
        chk(q[7:1], 7'h7F);
        wait_irq(600);
        apb(1'b0, tec_pkg::TEC_OFS_COUNT, 8'h00);
        chk(q[7:1], 7'h10);
        // event counting with the slowest prescale, which must not matter
        for (int g = 0; g < 2; g++)
        begin
            wr(tec_pkg::TEC_OFS_CONTROL, 8'h00);
            wr(tec_pkg::TEC_OFS_COUNT, 8'h00);
            // direction bits still all ones from reset, so the shared pin is an input
            wr(tec_pkg::TEC_OFS_CONTROL, {4'b0101, g[0], 3'b111});
            i_src.drive(1'b0, 4);
            rd(tec_pkg::TEC_OFS_COUNT, {31'h0, g[0]});
            i_src.drive(1'b1, 4);
            rd(tec_pkg::TEC_OFS_COUNT, 32'h1);
            repeat (3)
            begin
                i_src.drive(1'b0, 3);
                i_src.drive(1'b1, 3);
            end
            rd(tec_pkg::TEC_OFS_COUNT, 32'h4);
        end
        wr(tec_pkg::TEC_OFS_CONTROL, 8'h17);
        i_src.drive(1'b0, 3);
        i_src.drive(1'b1, 3);
        rd(tec_pkg::TEC_OFS_COUNT, 32'h4);
        // pulse width, both polarities; a pulse after the end is ignored
        for (int g = 0; g < 2; g++)
        begin
            wr(tec_pkg::TEC_OFS_CONTROL, 8'h00);
            wr(tec_pkg::TEC_OFS_COUNT, 8'h00);
            wr(tec_pkg::TEC_OFS_CONTROL, {4'b1101, g[0], 3'b000});
            i_src.drive(g[0] ? 1'b0 : 1'b1, 4);
            i_src.drive(g[0] ? 1'b1 : 1'b0, 20);
            i_src.drive(g[0] ? 1'b0 : 1'b1, 4);
            apb(1'b0, tec_pkg::TEC_OFS_COUNT, 8'h00);
            held = q[7:0];
            chk(held >= 8'h13 && held <= 8'h17, 32'h1);
            rd(tec_pkg::TEC_OFS_CONTROL, {28'h000000C, g[0], 3'b000});
            i_src.drive(g[0] ? 1'b1 : 1'b0, 6);
            i_src.drive(g[0] ? 1'b0 : 1'b1, 4);
            rd(tec_pkg::TEC_OFS_COUNT, {24'h000000, held});
        end
        i_src.drive(1'b1, 2);
        wr(tec_pkg::TEC_OFS_CONTROL, 8'h00);
        wr(tec_pkg::TEC_OFS_PORT_DIR, 8'hFE);
        wr(tec_pkg::TEC_OFS_PORT_DAT, 8'h00);
        // the data latch updates at the access edge; look once it has settled
        @(negedge pclk);
        chk({port_oe, port_out}, 32'h0100);
        rd(tec_pkg::TEC_OFS_PORT_DAT, 32'hFE);
        final_report();
    end

    // whole run needs under two thousand cycles
    initial
    begin
        repeat (20000) @(posedge pclk);
        err_count++;
        final_report();
    end
endmodule

`default_nettype wire
